// ===== line_ber_aps_defines.vh
// Operation
// - debounce on: sync nibble needs eight equal frames
// - debounce off: sync nibble written straight through
// - fail subtotal spans programmed frames, window eight
// - degrade subtotal spans programmed frames, window eight
// - fail errors capped at limit; all ones disables
// - degrade errors capped at limit; all ones disables
// - fail declared when window sum reaches threshold
// - fail removed when window sum below threshold
// - degrade declared when window sum reaches threshold
// - degrade removed when window sum below threshold
// - K1 updates after three equal differing frames
// - K2 updates after three equal differing frames
// - accepted K1/K2 change can raise enabled interrupt
// - monitor enable low resets accumulation and alarm
// - clear mode uses eight times longer window
// - saturation mode picks per frame or subtotal
// - events latch status bits; status read clears
`ifndef LINE_BER_APS_DEFINES_VH
`define LINE_BER_APS_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_IRQ_ENABLE 8'he0
`define IDX_IRQ_STATUS 8'he1
`define IDX_CONFIG 8'he2
`define IDX_SF_PERIOD_LOW 8'he3
`define IDX_SF_PERIOD_MID 8'he4
`define IDX_SF_PERIOD_HIGH 8'he5
`define IDX_SF_SAT_LOW 8'he6
`define IDX_SF_SAT_HIGH 8'he7
`define IDX_SF_DECLARE_LOW 8'he8
`define IDX_SF_DECLARE_HIGH 8'he9
`define IDX_SF_CLEAR_LOW 8'hea
`define IDX_SF_CLEAR_HIGH 8'heb
`define IDX_SD_PERIOD_LOW 8'hec
`define IDX_SD_PERIOD_MID 8'hed
`define IDX_SD_PERIOD_HIGH 8'hee
`define IDX_SD_SAT_LOW 8'hef
`define IDX_SD_SAT_HIGH 8'hf0
`define IDX_SD_DECLARE_LOW 8'hf1
`define IDX_SD_DECLARE_HIGH 8'hf2
`define IDX_SD_CLEAR_LOW 8'hf3
`define IDX_SD_CLEAR_HIGH 8'hf4
`define IDX_RX_K1 8'hf5
`define IDX_RX_K2 8'hf6
`define IDX_RX_SYNC 8'hf7

// configuration bit positions
`define CFG_SYNC_DEBOUNCE 7
`define CFG_FAIL_EN 6
`define CFG_FAIL_SAT_MODE 5
`define CFG_FAIL_CLR_MODE 4
`define CFG_DEG_EN 3
`define CFG_DEG_SAT_MODE 2
`define CFG_DEG_CLR_MODE 1
`define CFG_RESERVED 0

// interrupt enable / status bit positions
`define IRQ_APS_CHANGE 6
`define IRQ_SYNC_CHANGE 5
`define IRQ_FAIL 4
`define IRQ_DEGRADE 3
`define STAT_FAIL_STATE 2
`define STAT_DEG_STATE 1
`define IRQ_ENABLE_MASK 8'h78

// reset values and limits
`define CONFIG_RESET 8'h00
`define SAT_DISABLED 12'hfff
`define SUBTOTALS_DECLARE 8
`define SUBTOTALS_CLEAR 64
`define APS_PERSIST 2'd3
`define SYNC_PERSIST 4'd8

`endif

// ===== ber_alarm_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "line_ber_aps_defines.vh"

module ber_alarm_channel (
  input wire hclk,
  input wire hresetn,
  input wire monitor_en,
  input wire [23:0] subtotal_period,
  input wire [11:0] saturation_limit,
  input wire saturation_mode,
  input wire clear_window_mode,
  input wire [11:0] declare_threshold,
  input wire [11:0] clear_threshold,
  input wire frame_pulse,
  input wire [11:0] frame_errors,
  output reg alarm,
  output reg alarm_event
);

  reg [11:0] ring [0:63];
  reg [5:0] wr_ptr;
  reg [11:0] subtotal;
  reg [23:0] frame_cnt;
  reg [14:0] sum_short;
  reg [17:0] sum_long;
  wire sat_off = (saturation_limit == `SAT_DISABLED);
  reg [11:0] frame_capped;
  reg [12:0] raw_sum;
  reg [11:0] next_subtotal;
  reg boundary;
  reg [14:0] next_short;
  reg [17:0] next_long;
  reg next_alarm;
  integer i;

  // saturation per frame or per subtotal, sums at the boundary
  always @* begin
    frame_capped = frame_errors;
    if (!sat_off && !saturation_mode && frame_errors > saturation_limit)
      frame_capped = saturation_limit;
    raw_sum = {1'b0, subtotal} + {1'b0, frame_capped};
    if (raw_sum[12])
      next_subtotal = 12'hfff; // subtotal register never wraps
    else
      next_subtotal = raw_sum[11:0];
    if (!sat_off && saturation_mode && next_subtotal > saturation_limit)
      next_subtotal = saturation_limit;
    // period zero behaves like one frame per subtotal
    boundary = frame_pulse && (frame_cnt + 24'h000001 >= subtotal_period);
    // slide both windows by one subtotal
    next_short = sum_short + {3'b000, next_subtotal}
      - {3'b000, ring[wr_ptr - 6'd8]};
    next_long = sum_long + {6'b000000, next_subtotal}
      - {6'b000000, ring[wr_ptr]};
    next_alarm = alarm;
    if (!alarm && next_short >= {3'b000, declare_threshold})
      next_alarm = 1'b1;
    else if (alarm && clear_window_mode
             && next_long < {6'b000000, clear_threshold})
      next_alarm = 1'b0;
    else if (alarm && !clear_window_mode
             && next_short < {3'b000, clear_threshold})
      next_alarm = 1'b0;
  end

  // accumulation and alarm state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= 6'd0;
      subtotal <= 12'h000;
      frame_cnt <= 24'h000000;
      sum_short <= 15'h0000;
      sum_long <= 18'h00000;
      alarm <= 1'b0;
      alarm_event <= 1'b0;
      for (i = 0; i < `SUBTOTALS_CLEAR; i = i + 1)
        ring[i] <= 12'h000;
    end else if (!monitor_en) begin
      // back to declaration monitoring with empty windows
      wr_ptr <= 6'd0;
      subtotal <= 12'h000;
      frame_cnt <= 24'h000000;
      sum_short <= 15'h0000;
      sum_long <= 18'h00000;
      alarm <= 1'b0;
      alarm_event <= alarm; // dropping an active alarm is a removal
      for (i = 0; i < `SUBTOTALS_CLEAR; i = i + 1)
        ring[i] <= 12'h000;
    end else begin
      alarm_event <= 1'b0;
      if (boundary) begin
        ring[wr_ptr] <= next_subtotal;
        wr_ptr <= wr_ptr + 6'd1;
        sum_short <= next_short;
        sum_long <= next_long;
        subtotal <= 12'h000;
        frame_cnt <= 24'h000000;
        alarm <= next_alarm;
        alarm_event <= (next_alarm != alarm);
      end else if (frame_pulse) begin
        subtotal <= next_subtotal;
        frame_cnt <= frame_cnt + 24'h000001;
      end
    end
  end

endmodule
`default_nettype wire

// ===== line_ber_aps_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "line_ber_aps_defines.vh"

module line_ber_aps_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire frame_pulse,
  input wire [11:0] b2_errors,
  input wire [7:0] k1_in,
  input wire [7:0] k2_in,
  input wire [7:0] sync_in,
  output wire irq,
  output wire fail_alarm,
  output wire degrade_alarm
);

  // register bytes written by software
  reg [7:0] irq_enable;
  reg [7:0] config_reg;
  reg [23:0] fail_subtotal_period;
  reg [11:0] fail_saturation_limit;
  reg [11:0] fail_declare_threshold;
  reg [11:0] fail_clear_threshold;
  reg [23:0] degrade_subtotal_period;
  reg [11:0] degrade_saturation_limit;
  reg [11:0] degrade_declare_threshold;
  reg [11:0] degrade_clear_threshold;

  // received overhead state
  reg [7:0] aps_stored [0:1];
  reg [7:0] aps_cand [0:1];
  reg [1:0] aps_cnt [0:1];
  reg [1:0] aps_accept;
  reg [7:0] sync_stored;
  reg [3:0] sync_cand;
  reg [3:0] sync_cnt;
  reg sync_event;
  reg [3:0] irq_status;

  // bus phase tracking
  reg wr_pending;
  reg rd_pending;
  reg [7:0] dp_index;
  reg [7:0] rd_byte;
  reg status_read;

  wire [7:0] aps_in [0:1];
  wire [1:0] alarm_state;
  wire [1:0] alarm_event;
  wire [23:0] ch_period [0:1];
  wire [11:0] ch_sat [0:1];
  wire [11:0] ch_declare [0:1];
  wire [11:0] ch_clear [0:1];
  wire [1:0] ch_en;
  wire [1:0] ch_sat_mode;
  wire [1:0] ch_clr_mode;
  wire addr_take;
  wire sync_debounce_en;

  assign aps_in[0] = k1_in;
  assign aps_in[1] = k2_in;
  assign sync_debounce_en = config_reg[`CFG_SYNC_DEBOUNCE];

  // AHB-Lite: writes need no wait, reads take one wait state
  assign addr_take = hsel && hready && htrans[1];
  assign hreadyout = ~rd_pending;
  assign hresp = 1'b0;

  // upper nibble of a 12-bit value, padded for the byte lane
  function [7:0] high_nibble;
    input [11:0] value;
    begin
      high_nibble = {4'h0, value[11:8]};
    end
  endfunction

  // write merge for the low and high byte of a 12-bit field
  function [11:0] merge12;
    input [11:0] old;
    input hi;
    input [7:0] data;
    begin
      if (hi)
        merge12 = {data[3:0], old[7:0]};
      else
        merge12 = {old[11:8], data};
    end
  endfunction

  // read mux; unmapped indices read as zero
  always @* begin
    case (dp_index)
      `IDX_IRQ_ENABLE: rd_byte = irq_enable;
      `IDX_IRQ_STATUS: rd_byte = {1'b0, irq_status, alarm_state, 1'b0};
      `IDX_CONFIG: rd_byte = config_reg;
      `IDX_SF_PERIOD_LOW: rd_byte = fail_subtotal_period[7:0];
      `IDX_SF_PERIOD_MID: rd_byte = fail_subtotal_period[15:8];
      `IDX_SF_PERIOD_HIGH: rd_byte = fail_subtotal_period[23:16];
      `IDX_SF_SAT_LOW: rd_byte = fail_saturation_limit[7:0];
      `IDX_SF_SAT_HIGH: rd_byte = high_nibble(fail_saturation_limit);
      `IDX_SF_DECLARE_LOW: rd_byte = fail_declare_threshold[7:0];
      `IDX_SF_DECLARE_HIGH: rd_byte = high_nibble(fail_declare_threshold);
      `IDX_SF_CLEAR_LOW: rd_byte = fail_clear_threshold[7:0];
      `IDX_SF_CLEAR_HIGH: rd_byte = high_nibble(fail_clear_threshold);
      `IDX_SD_PERIOD_LOW: rd_byte = degrade_subtotal_period[7:0];
      `IDX_SD_PERIOD_MID: rd_byte = degrade_subtotal_period[15:8];
      `IDX_SD_PERIOD_HIGH: rd_byte = degrade_subtotal_period[23:16];
      `IDX_SD_SAT_LOW: rd_byte = degrade_saturation_limit[7:0];
      `IDX_SD_SAT_HIGH: rd_byte = high_nibble(degrade_saturation_limit);
      `IDX_SD_DECLARE_LOW: rd_byte = degrade_declare_threshold[7:0];
      `IDX_SD_DECLARE_HIGH:
        rd_byte = high_nibble(degrade_declare_threshold);
      `IDX_SD_CLEAR_LOW: rd_byte = degrade_clear_threshold[7:0];
      `IDX_SD_CLEAR_HIGH: rd_byte = high_nibble(degrade_clear_threshold);
      `IDX_RX_K1: rd_byte = aps_stored[0];
      `IDX_RX_K2: rd_byte = aps_stored[1];
      `IDX_RX_SYNC: rd_byte = sync_stored;
      default: rd_byte = 8'h00;
    endcase
  end

  // clear lands on the edge that latches the byte, so nothing is lost
  always @* begin
    status_read = rd_pending && (dp_index == `IDX_IRQ_STATUS);
  end

  // address phase capture and read data register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      dp_index <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      if (rd_pending) begin
        // second data cycle: data and side effect land together
        hrdata <= {24'h000000, rd_byte};
        rd_pending <= 1'b0;
      end else begin
        wr_pending <= addr_take && hwrite;
        rd_pending <= addr_take && !hwrite;
        if (addr_take)
          dp_index <= haddr[9:2];
      end
    end
  end

  // software writes; reserved config bit stored as written
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable <= 8'h00;
      config_reg <= `CONFIG_RESET;
      fail_subtotal_period <= 24'h000000;
      fail_saturation_limit <= 12'h000;
      fail_declare_threshold <= 12'h000;
      fail_clear_threshold <= 12'h000;
      degrade_subtotal_period <= 24'h000000;
      degrade_saturation_limit <= 12'h000;
      degrade_declare_threshold <= 12'h000;
      degrade_clear_threshold <= 12'h000;
    end else if (wr_pending) begin
      case (dp_index)
        `IDX_IRQ_ENABLE: irq_enable <= hwdata[7:0] & `IRQ_ENABLE_MASK;
        `IDX_CONFIG: config_reg <= hwdata[7:0];
        `IDX_SF_PERIOD_LOW: fail_subtotal_period[7:0] <= hwdata[7:0];
        `IDX_SF_PERIOD_MID: fail_subtotal_period[15:8] <= hwdata[7:0];
        `IDX_SF_PERIOD_HIGH: fail_subtotal_period[23:16] <= hwdata[7:0];
        `IDX_SF_SAT_LOW, `IDX_SF_SAT_HIGH:
          fail_saturation_limit <= merge12(fail_saturation_limit,
            dp_index == `IDX_SF_SAT_HIGH, hwdata[7:0]);
        `IDX_SF_DECLARE_LOW, `IDX_SF_DECLARE_HIGH:
          fail_declare_threshold <= merge12(fail_declare_threshold,
            dp_index == `IDX_SF_DECLARE_HIGH, hwdata[7:0]);
        `IDX_SF_CLEAR_LOW, `IDX_SF_CLEAR_HIGH:
          fail_clear_threshold <= merge12(fail_clear_threshold,
            dp_index == `IDX_SF_CLEAR_HIGH, hwdata[7:0]);
        `IDX_SD_PERIOD_LOW: degrade_subtotal_period[7:0] <= hwdata[7:0];
        `IDX_SD_PERIOD_MID: degrade_subtotal_period[15:8] <= hwdata[7:0];
        `IDX_SD_PERIOD_HIGH:
          degrade_subtotal_period[23:16] <= hwdata[7:0];
        `IDX_SD_SAT_LOW, `IDX_SD_SAT_HIGH:
          degrade_saturation_limit <= merge12(degrade_saturation_limit,
            dp_index == `IDX_SD_SAT_HIGH, hwdata[7:0]);
        `IDX_SD_DECLARE_LOW, `IDX_SD_DECLARE_HIGH:
          degrade_declare_threshold <= merge12(degrade_declare_threshold,
            dp_index == `IDX_SD_DECLARE_HIGH, hwdata[7:0]);
        `IDX_SD_CLEAR_LOW, `IDX_SD_CLEAR_HIGH:
          degrade_clear_threshold <= merge12(degrade_clear_threshold,
            dp_index == `IDX_SD_CLEAR_HIGH, hwdata[7:0]);
        default: irq_enable <= irq_enable; // read-only or unmapped
      endcase
    end
  end

  // channel 0 is signal fail, channel 1 is signal degrade
  assign ch_period[0] = fail_subtotal_period;
  assign ch_period[1] = degrade_subtotal_period;
  assign ch_sat[0] = fail_saturation_limit;
  assign ch_sat[1] = degrade_saturation_limit;
  assign ch_declare[0] = fail_declare_threshold;
  assign ch_declare[1] = degrade_declare_threshold;
  assign ch_clear[0] = fail_clear_threshold;
  assign ch_clear[1] = degrade_clear_threshold;
  assign ch_en = {config_reg[`CFG_DEG_EN], config_reg[`CFG_FAIL_EN]};
  assign ch_sat_mode = {config_reg[`CFG_DEG_SAT_MODE],
                        config_reg[`CFG_FAIL_SAT_MODE]};
  assign ch_clr_mode = {config_reg[`CFG_DEG_CLR_MODE],
                        config_reg[`CFG_FAIL_CLR_MODE]};
  assign fail_alarm = alarm_state[1];
  assign degrade_alarm = alarm_state[0];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ber
      // alarm_state keeps status-register order: fail high, degrade low
      ber_alarm_channel u_channel (
        .hclk(hclk),
        .hresetn(hresetn),
        .monitor_en(ch_en[g]),
        .subtotal_period(ch_period[g]),
        .saturation_limit(ch_sat[g]),
        .saturation_mode(ch_sat_mode[g]),
        .clear_window_mode(ch_clr_mode[g]),
        .declare_threshold(ch_declare[g]),
        .clear_threshold(ch_clear[g]),
        .frame_pulse(frame_pulse),
        .frame_errors(b2_errors),
        .alarm(alarm_state[1 - g]),
        .alarm_event(alarm_event[1 - g])
      );
    end
  endgenerate

  // K1 and K2 persistence: a differing value must repeat three times
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_aps
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          aps_stored[g] <= 8'h00;
          aps_cand[g] <= 8'h00;
          aps_cnt[g] <= 2'd0;
          aps_accept[g] <= 1'b0;
        end else begin
          aps_accept[g] <= 1'b0;
          if (frame_pulse) begin
            if (aps_in[g] == aps_stored[g]) begin
              aps_cnt[g] <= 2'd0;
            end else if (aps_in[g] == aps_cand[g] && aps_cnt[g] != 2'd0)
            begin
              if (aps_cnt[g] + 2'd1 == `APS_PERSIST) begin
                aps_stored[g] <= aps_in[g];
                aps_accept[g] <= 1'b1;
                aps_cnt[g] <= 2'd0;
              end else begin
                aps_cnt[g] <= aps_cnt[g] + 2'd1;
              end
            end else begin
              aps_cand[g] <= aps_in[g];
              aps_cnt[g] <= 2'd1;
            end
          end
        end
      end
    end
  endgenerate

  // sync nibble capture, optionally debounced over eight frames
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_stored <= 8'h00;
      sync_cand <= 4'h0;
      sync_cnt <= 4'd0;
      sync_event <= 1'b0;
    end else begin
      sync_event <= 1'b0;
      if (frame_pulse) begin
        if (!sync_debounce_en) begin
          sync_stored <= sync_in;
          sync_event <= (sync_in[3:0] != sync_stored[3:0]);
          sync_cnt <= 4'd0;
        end else if (sync_in[3:0] == sync_cand && sync_cnt != 4'd0) begin
          if (sync_cnt + 4'd1 >= `SYNC_PERSIST) begin
            // upper nibble follows only on a confirmed lower nibble
            sync_stored <= sync_in;
            sync_event <= (sync_in[3:0] != sync_stored[3:0]);
            sync_cnt <= `SYNC_PERSIST;
          end else begin
            sync_cnt <= sync_cnt + 4'd1;
          end
        end else begin
          sync_cand <= sync_in[3:0];
          sync_cnt <= 4'd1;
        end
      end
    end
  end

  // sticky status; a new event beats a read-clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= (status_read ? 4'h0 : irq_status)
        | {|aps_accept, sync_event, alarm_event};
    end
  end

  // one interrupt line, gated by the enable byte
  assign irq = |(irq_status & irq_enable[6:3]);

endmodule
`default_nettype wire

// ===== line_ber_aps_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module line_ber_aps_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frame_pulse,
  input wire logic [11:0] b2_errors,
  input wire logic [7:0] k1_in,
  input wire logic [7:0] k2_in,
  input wire logic [7:0] sync_in,
  input wire logic irq,
  input wire logic fail_alarm,
  input wire logic degrade_alarm
);
  logic rd_taken;
  logic wr_taken;
  // address phases accepted by the slave
  assign rd_taken = hsel && hready && htrans[1] && !hwrite;
  assign wr_taken = hsel && hready && htrans[1] && hwrite;
  default clocking main_clk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // reads cost one wait state, writes none
  a_read_one_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (wr_taken |=> hreadyout)
    else $error("write stalled");
  a_idle_is_ready: assert property (!rd_taken |=> hreadyout)
    else $error("ready low without a read");
  a_ready_low_once: assert property ($fell(hreadyout) |=> hreadyout)
    else $error("ready low too long");
  a_resp_always_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  // registers are a byte wide, upper read data zero
  a_rdata_upper_zero: assert property (rd_taken |-> ##2 hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // alarms are only declared at a subtotal boundary frame
  a_fail_rise_frame: assert property ($rose(fail_alarm)
    |-> $past(frame_pulse))
    else $error("fail alarm rose off a frame");
  a_degrade_rise_frame: assert property ($rose(degrade_alarm)
    |-> $past(frame_pulse))
    else $error("degrade alarm rose off a frame");
endmodule

bind line_ber_aps_monitor line_ber_aps_checker line_ber_aps_checker_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
  .hwdata, .hrdata, .hreadyout, .hresp, .frame_pulse, .b2_errors,
  .k1_in, .k2_in, .sync_in, .irq, .fail_alarm, .degrade_alarm);
`default_nettype wire

// ===== line_frame_source.sv
`timescale 1ns/1ps
`default_nettype none
module line_frame_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [7:0] count,
  input wire logic [11:0] err_v,
  input wire logic [7:0] k1_v,
  input wire logic [7:0] k2_v,
  input wire logic [7:0] sync_v,
  output logic frame_pulse,
  output logic [11:0] b2_errors,
  output logic [7:0] k1_in,
  output logic [7:0] k2_in,
  output logic [7:0] sync_in,
  output logic busy
);
  logic [7:0] left;
  logic [1:0] gap;
  // between frames the lines carry the inverse, so a stale byte never helps
  assign busy = left != 8'h00;
  assign b2_errors = frame_pulse ? err_v : ~err_v;
  assign k1_in = frame_pulse ? k1_v : ~k1_v;
  assign k2_in = frame_pulse ? k2_v : ~k2_v;
  assign sync_in = frame_pulse ? sync_v : ~sync_v;
  // one frame every four clocks; real spacing is far longer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left <= 8'h00;
      gap <= 2'h0;
      frame_pulse <= 1'b0;
    end else if (load) begin
      left <= count;
      gap <= 2'h0;
      frame_pulse <= 1'b0;
    end else begin
      gap <= gap + 2'h1;
      frame_pulse <= busy && gap == 2'h3;
      if (busy && gap == 2'h3)
        left <= left - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== tb_line_ber_aps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_line_ber_aps_monitor;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, frame_pulse;
  logic irq, fail_alarm, degrade_alarm, load, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [11:0] b2_errors, err_v;
  logic [7:0] k1_in, k2_in, sync_in, k1_v, k2_v, sync_v, count, rd;
  int miscompares, compares;
  // writable bytes, read-only and unmapped places with their readback
  row_t rows[23] = '{'{8'he3, 8'ha5, 8'ha5}, '{8'he4, 8'h5a, 8'h5a},
    '{8'he5, 8'hc3, 8'hc3}, '{8'he6, 8'h3c, 8'h3c}, '{8'he7, 8'h0a, 8'h0a},
    '{8'he8, 8'h96, 8'h96}, '{8'he9, 8'h05, 8'h05}, '{8'hea, 8'h69, 8'h69},
    '{8'heb, 8'h03, 8'h03}, '{8'hec, 8'h81, 8'h81}, '{8'hed, 8'h18, 8'h18},
    '{8'hee, 8'h7e, 8'h7e}, '{8'hef, 8'he7, 8'he7}, '{8'hf0, 8'h0c, 8'h0c},
    '{8'hf1, 8'h42, 8'h42}, '{8'hf2, 8'h01, 8'h01}, '{8'hf3, 8'h24, 8'h24},
    '{8'hf4, 8'h0e, 8'h0e}, '{8'he0, 8'hff, 8'h78}, '{8'he1, 8'hff, 8'h00},
    '{8'hf5, 8'hff, 8'h00}, '{8'hf7, 8'hff, 8'h00}, '{8'h10, 8'hff, 8'h00}};
  // period, saturation, declare, clear bytes from the fail and degrade bases
  logic [7:0] fail_set[9] = '{2, 0, 0, 5, 0, 11, 0, 5, 0};
  logic [7:0] deg_set[9] = '{1, 0, 0, 2, 0, 10, 0, 3, 0};

  line_ber_aps_monitor line_ber_aps_monitor_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'b010), .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .frame_pulse, .b2_errors, .k1_in, .k2_in,
    .sync_in, .irq, .fail_alarm, .degrade_alarm);
  line_frame_source line_frame_source_inst (.hclk, .hresetn, .load, .count,
    .err_v, .k1_v, .k2_v, .sync_v, .frame_pulse, .b2_errors, .k1_in,
    .k2_in, .sync_in, .busy);

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  // ready is looked at mid-cycle, where it has settled before the edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    rd = hrdata[7:0];
    @(posedge hclk);
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy();
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp,
                       input string what);
    bus(1'b0, idx, 8'h00);
    check(rd, exp, what);
  endtask

  // irq, fail and degrade levels, in that order
  task automatic pins(input logic [2:0] exp, input string what);
    @(negedge hclk);
    check({5'h0, irq, fail_alarm, degrade_alarm}, {5'h0, exp}, what);
    @(posedge hclk);
  endtask

  task automatic setup(input logic [7:0] base, input logic [7:0] v[9]);
    for (int i = 0; i < 9; i++)
      bus(1'b1, base + i[7:0], v[i]);
  endtask

  // send n equal frames; K2 carries the inverse of K1
  task automatic frames(input logic [7:0] n, input logic [11:0] e,
                        input logic [7:0] k, input logic [7:0] s);
    int t;
    err_v <= e;
    k1_v <= k;
    k2_v <= ~k;
    sync_v <= s;
    count <= n;
    load <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
    t = 0;
    @(negedge hclk);
    while (busy !== 1'b0 && t < 2000) begin
      @(negedge hclk);
      t++;
    end
    if (t >= 2000) begin
      miscompares++;
      summarize();
    end
    repeat (3) @(posedge hclk);
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, load, htrans} = 5'h00;
    {haddr, hwdata} = 64'h0;
    {count, k1_v, k2_v, sync_v, err_v} = 44'h0;
    compares = 0;
    miscompares = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 224; i < 248; i++)
      rdchk(i[7:0], 8'h00, "reset value");
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rdchk(rows[i].idx, rows[i].exp, "register access");
    end
    $display("test registers done");
    frames(2, 0, 8'h5a, 0);
    rdchk(8'hf5, 8'h00, "k1 after two");
    frames(1, 0, 8'h33, 0);
    frames(2, 0, 8'h5a, 0);
    rdchk(8'hf5, 8'h00, "k1 broken run");
    frames(1, 0, 8'h5a, 0);
    rdchk(8'hf5, 8'h5a, "k1 accepted");
    rdchk(8'hf6, 8'ha5, "k2 accepted");
    pins(3'b100, "aps change irq");
    rdchk(8'he1, 8'h40, "aps status");
    pins(3'b000, "status read clears");
    bus(1'b1, 8'he0, 8'h00);
    frames(3, 0, 8'h11, 0);
    pins(3'b000, "aps irq masked");
    rdchk(8'he1, 8'h40, "masked status");
    bus(1'b1, 8'he0, 8'h78);
    $display("test protection bytes done");
    bus(1'b1, 8'he2, 8'h80);
    frames(7, 0, 8'h11, 8'h93);
    rdchk(8'hf7, 8'h00, "sync after seven");
    frames(1, 0, 8'h11, 8'h93);
    rdchk(8'hf7, 8'h93, "sync after eight");
    rdchk(8'he1, 8'h20, "sync status");
    bus(1'b1, 8'he2, 8'h00);
    frames(1, 0, 8'h11, 8'h0c);
    rdchk(8'hf7, 8'h0c, "sync direct");
    $display("test sync done");
    setup(8'hec, deg_set);
    bus(1'b1, 8'he2, 8'h08);
    frames(4, 12'h007, 8'h11, 8'h0c);
    pins(3'b100, "degrade capped");
    frames(1, 12'h007, 8'h11, 8'h0c);
    pins(3'b101, "degrade declared");
    bus(1'b1, 8'he2, 8'h00);
    repeat (2) @(posedge hclk);
    pins(3'b100, "degrade disabled");
    rdchk(8'he1, 8'h28, "degrade events");
    $display("test degrade done");
    setup(8'he3, fail_set);
    bus(1'b1, 8'he2, 8'h60);
    frames(4, 12'h003, 8'h11, 8'h0c);
    pins(3'b000, "fail subtotal capped");
    frames(2, 12'h003, 8'h11, 8'h0c);
    pins(3'b110, "fail declared");
    frames(14, 12'h000, 8'h11, 8'h0c);
    pins(3'b110, "fail at clear level");
    frames(2, 12'h000, 8'h11, 8'h0c);
    pins(3'b100, "fail removed");
    rdchk(8'he1, 8'h10, "fail events");
    $display("test fail done");
    bus(1'b1, 8'he2, 8'h0a);
    frames(5, 12'h007, 8'h11, 8'h0c);
    frames(62, 12'h000, 8'h11, 8'h0c);
    pins(3'b101, "degrade held by long window");
    frames(1, 12'h000, 8'h11, 8'h0c);
    pins(3'b100, "degrade cleared on long window");
    $display("test clear window done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    pins(3'b000, "outputs after reset");
    rdchk(8'he2, 8'h00, "config after reset");
    rdchk(8'hf5, 8'h00, "k1 after reset");
    $display("test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
